// *** rtl/clk_src_consts.svh ***
// constants for the system clock source selector
`ifndef CLK_SRC_CONSTS_SVH
`define CLK_SRC_CONSTS_SVH
`define SRC_FAST_RC 3'h0
`define SRC_FAST_RC_PLL 3'h1
`define SRC_PRIMARY 3'h2
`define SRC_PRIMARY_PLL 3'h3
`define SRC_SECONDARY 3'h4
`define SRC_LOW_POWER_RC 3'h5
`define SRC_RESERVED 3'h6
`define SRC_FAST_RC_DIV 3'h7
`define PMODE_EXT_CLOCK 2'h0
`define PMODE_STD_CRYSTAL 2'h1
`define PMODE_HS_CRYSTAL 2'h2
`define PMODE_OFF 2'h3
`define SRC_SEL_W 3
`define FAST_RC_HZ 8000000
`define USB_PLL_HZ 96000000
`define USB_CLK_HZ 48000000
`define SYS_CLK_HZ 40000000
`define FAIL_TIMEOUT_NS 2000
`define FAIL_TIMEOUT_CYC ((`FAIL_TIMEOUT_NS * 40 + 999) / 1000)
`endif

// *** rtl/clk_src_pkg.sv ***
// types shared by the clock source selector
package clk_src_pkg;
  typedef enum logic [2:0] {
    SRC_FRC = 3'h0,
    SRC_FRC_PLL = 3'h1,
    SRC_PRI = 3'h2,
    SRC_PRI_PLL = 3'h3,
    SRC_SEC = 3'h4,
    SRC_LOW_POWER_INTERNAL_RC = 3'h5,
    SRC_RSVD = 3'h6,
    SRC_FRC_DIV = 3'h7
  } source_t;

  typedef enum logic [2:0] {
    PM_NONE = 3'h0,
    PM_EXT = 3'h1,
    PM_STD = 3'h2,
    PM_HS = 3'h3,
    PM_EXT_PLL = 3'h4,
    PM_XT_PLL = 3'h5
  } pri_mode_t;

  typedef struct packed {
    logic [1:0] primaryModeCfg;
    logic [2:0] initialSourceCfg;
    logic [1:0] switchMonitorCfg;
    logic oscOutPinFunctionCfg;
  } config_t;

  typedef struct packed {
    logic [2:0] currentSourceField;
    logic switchBusy;
    logic clockFailFlag;
    logic monitorEnabled;
    logic switchEnabled;
    logic configValid;
  } status_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_WAIT_OLD = 2'b01,
    SW_WAIT_NEW = 2'b11
  } sw_state_t;
endpackage

// *** rtl/clock_mux_gate.sv ***
// glitch-free gated clock select leg
module clock_mux_gate (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic selReq,
  input wire logic srcTick,
  output logic gateOn,
  output logic tickOut
);
  // enable only changes when the source tick is low, so no pulse is cut
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      gateOn <= 1'b0;
    else if (!srcTick)
      gateOn <= selReq;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      tickOut <= 1'b0;
    else
      tickOut <= srcTick & gateOn;
  end
endmodule

// *** rtl/system_clock_source_select.sv ***
// system clock source selector with switching and fail-safe monitor
`include "clk_src_consts.svh"
module system_clock_source_select #(
  parameter int FAIL_TIMEOUT = `FAIL_TIMEOUT_CYC,
  parameter int DIV_W = 3
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire clk_src_pkg::config_t cfgIn,
  input wire logic primaryOscTick,
  input wire logic secondaryOscTick,
  input wire logic fastRcTick,
  input wire logic lowPowerRcTick,
  input wire logic pllSysTick,
  input wire logic pllUsbTick,
  input wire logic [DIV_W-1:0] fastRcDivSel,
  input wire logic switchRequestSet,
  input wire logic [2:0] newSourceField,
  input wire logic clockFailClear,
  output logic sysClkTick,
  output logic instrClkTick,
  output logic usbClkTick,
  output logic oscOutPinO,
  output logic oscOutPinOe,
  output logic pllEnable,
  output clk_src_pkg::pri_mode_t primaryMode,
  output logic switchRequestBit,
  output clk_src_pkg::status_t status
);
  import clk_src_pkg::*;

  // maps a source code plus primary mode to its oscillator mode
  function automatic pri_mode_t decode_mode(input logic [2:0] src, input logic [1:0] pm);
    pri_mode_t m;
    m = PM_NONE;
    if (src == `SRC_PRIMARY_PLL)
    begin
      if (pm == `PMODE_STD_CRYSTAL)
        m = PM_XT_PLL;
      else if (pm == `PMODE_EXT_CLOCK)
        m = PM_EXT_PLL;
    end
    else if (src == `SRC_PRIMARY)
    begin
      case (pm)
        `PMODE_HS_CRYSTAL: m = PM_HS;
        `PMODE_STD_CRYSTAL: m = PM_STD;
        `PMODE_EXT_CLOCK: m = PM_EXT;
        default: m = PM_NONE;
      endcase
    end
    return m;
  endfunction

  // validity of a code with the primary mode field
  function automatic logic src_valid(input logic [2:0] src, input logic [1:0] pm);
    logic v;
    v = 1'b0;
    case (src)
      `SRC_RESERVED: v = 1'b0;
      `SRC_PRIMARY, `SRC_PRIMARY_PLL: v = (decode_mode(src, pm) != PM_NONE);
      default: v = 1'b1;
    endcase
    return v;
  endfunction

  // 3-flop filter for the asynchronous oscillator ticks
  logic [3:0][2:0] syncQ;
  logic [3:0] tickQ;
  logic [3:0] rawTick;
  assign rawTick = {lowPowerRcTick, secondaryOscTick, primaryOscTick, fastRcTick};
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      syncQ <= '0;
      tickQ <= '0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        syncQ[i] <= {syncQ[i][1:0], rawTick[i]};
        if (syncQ[i][1] == syncQ[i][2])
          tickQ[i] <= syncQ[i][2];
      end
    end
  end

  logic [2:0] pllSyncQ;
  logic pllTickQ;
  logic [2:0] usbSyncQ;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pllSyncQ <= '0;
      pllTickQ <= 1'b0;
      usbSyncQ <= '0;
    end
    else
    begin
      pllSyncQ <= {pllSyncQ[1:0], pllSysTick};
      usbSyncQ <= {usbSyncQ[1:0], pllUsbTick};
      if (pllSyncQ[1] == pllSyncQ[2])
        pllTickQ <= pllSyncQ[2];
    end
  end

  // configuration captured once, at the first edge after reset release
  config_t cfgQ;
  logic cfgDoneQ;
  logic [2:0] curSrcQ;
  logic [2:0] curSrcD;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cfgQ <= '1;
      cfgDoneQ <= 1'b0;
    end
    else if (!cfgDoneQ)
    begin
      cfgQ <= cfgIn;
      cfgDoneQ <= 1'b1;
    end
  end

  logic switchEn;
  logic monitorEn;
  assign switchEn = cfgDoneQ & ~cfgQ.switchMonitorCfg[1];
  assign monitorEn = cfgDoneQ & (cfgQ.switchMonitorCfg == 2'b00);

  // fast RC postscaler divides by 2^sel
  logic [7:0] divCntQ;
  logic divTickQ;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      divCntQ <= '0;
      divTickQ <= 1'b0;
    end
    else if (tickQ[0] & ~syncQ[0][2])
    begin
      divCntQ <= divCntQ + 8'h01;
    end
    else
      divTickQ <= (fastRcDivSel == '0) ? tickQ[0] : divCntQ[fastRcDivSel - 1'b1];
  end

  // per-source tick ahead of gating, indexed by source code
  logic [7:0] srcTick;
  always_comb
  begin
    srcTick = '0;
    srcTick[`SRC_FAST_RC] = tickQ[0];
    srcTick[`SRC_FAST_RC_PLL] = pllTickQ;
    srcTick[`SRC_PRIMARY] = tickQ[1];
    srcTick[`SRC_PRIMARY_PLL] = pllTickQ;
    srcTick[`SRC_SECONDARY] = tickQ[2];
    srcTick[`SRC_LOW_POWER_RC] = tickQ[3];
    srcTick[`SRC_FAST_RC_DIV] = divTickQ;
  end

  // switching state machine: drop old gate, then raise new gate
  sw_state_t swQ;
  logic [2:0] targetQ;
  logic [7:0] gateReq;
  logic [7:0] gateOn;
  logic [7:0] gated;
  logic reqQ;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      swQ <= SW_IDLE;
      targetQ <= `SRC_FAST_RC_DIV;
      reqQ <= 1'b0;
    end
    else
    begin
      case (swQ)
        SW_IDLE:
        begin
          if (switchRequestSet & switchEn & src_valid(newSourceField, cfgQ.primaryModeCfg))
          begin
            targetQ <= newSourceField;
            reqQ <= 1'b1;
            swQ <= SW_WAIT_OLD;
          end
        end
        SW_WAIT_OLD:
          if (gateOn == '0)
            swQ <= SW_WAIT_NEW;
        SW_WAIT_NEW:
          if (gateOn[targetQ])
          begin
            reqQ <= 1'b0;
            swQ <= SW_IDLE;
          end
        default: swQ <= SW_IDLE;
      endcase
    end
  end

  // power-on source, then switch target once a switch finishes
  always_comb
  begin
    curSrcD = curSrcQ;
    if (!cfgDoneQ)
      curSrcD = `SRC_FAST_RC_DIV;
    else if (swQ == SW_IDLE && curSrcQ == `SRC_RESERVED)
      curSrcD = `SRC_FAST_RC_DIV;
    else if (swQ == SW_WAIT_NEW && gateOn[targetQ])
      curSrcD = targetQ;
  end
  logic firstQ;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      curSrcQ <= `SRC_FAST_RC_DIV;
      firstQ <= 1'b1;
    end
    else if (firstQ & cfgDoneQ)
    begin
      // invalid power-on code falls back to fast RC with postscaler
      curSrcQ <= src_valid(cfgQ.initialSourceCfg, cfgQ.primaryModeCfg) ?
                 cfgQ.initialSourceCfg : `SRC_FAST_RC_DIV;
      firstQ <= 1'b0;
    end
    else
      curSrcQ <= curSrcD;
  end

  always_comb
  begin
    gateReq = '0;
    if (swQ == SW_IDLE)
      gateReq[curSrcQ] = cfgDoneQ & ~firstQ;
    else if (swQ == SW_WAIT_NEW)
      gateReq[targetQ] = 1'b1;
  end

  for (genvar g = 0; g < 8; g++)
  begin : gLeg
    clock_mux_gate uGate (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .selReq(gateReq[g]),
      .srcTick(srcTick[g]),
      .gateOn(gateOn[g]),
      .tickOut(gated[g])
    );
  end

  // fail-safe monitor: no edge on the running source within the timeout
  logic [15:0] failCntQ;
  logic failFlagQ;
  logic lastTickQ;
  logic failEvent;
  assign failEvent = monitorEn && swQ == SW_IDLE && failCntQ == 16'(FAIL_TIMEOUT);
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      failCntQ <= '0;
      lastTickQ <= 1'b0;
    end
    else
    begin
      lastTickQ <= srcTick[curSrcQ];
      if (srcTick[curSrcQ] != lastTickQ || swQ != SW_IDLE || failEvent)
        failCntQ <= '0;
      else
        failCntQ <= failCntQ + 16'h0001;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      failFlagQ <= 1'b0;
    else if (failEvent)
      failFlagQ <= 1'b1;
    else if (clockFailClear)
      failFlagQ <= 1'b0;
  end

  // outputs, instruction clock at half rate
  logic sysQ;
  logic instrQ;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sysQ <= 1'b0;
      instrQ <= 1'b0;
      sysClkTick <= 1'b0;
      instrClkTick <= 1'b0;
      usbClkTick <= 1'b0;
      oscOutPinO <= 1'b0;
      oscOutPinOe <= 1'b0;
      pllEnable <= 1'b0;
      primaryMode <= PM_NONE;
      switchRequestBit <= 1'b0;
      status <= '0;
    end
    else
    begin
      sysQ <= |gated;
      if (|gated & ~sysQ)
        instrQ <= ~instrQ;
      sysClkTick <= sysQ;
      instrClkTick <= instrQ;
      usbClkTick <= usbSyncQ[2];
      primaryMode <= decode_mode(curSrcQ, cfgQ.primaryModeCfg);
      pllEnable <= (curSrcQ == `SRC_FAST_RC_PLL) || (curSrcQ == `SRC_PRIMARY_PLL);
      if (curSrcQ == `SRC_PRIMARY && cfgQ.primaryModeCfg == `PMODE_EXT_CLOCK)
      begin
        oscOutPinOe <= 1'b1;
        oscOutPinO <= instrQ;
      end
      else if (cfgQ.primaryModeCfg == `PMODE_OFF)
      begin
        // pin function bit low: pin carries instruction clock
        oscOutPinOe <= ~cfgQ.oscOutPinFunctionCfg;
        oscOutPinO <= instrQ;
      end
      else
      begin
        oscOutPinOe <= 1'b0;
        oscOutPinO <= 1'b0;
      end
      switchRequestBit <= reqQ;
      status <= '{currentSourceField: curSrcQ, switchBusy: swQ != SW_IDLE,
                  clockFailFlag: failFlagQ, monitorEnabled: monitorEn,
                  switchEnabled: switchEn, configValid: cfgDoneQ & ~firstQ};
    end
  end
endmodule

// *** test/osc_partner.sv ***
// crystal or external clock model on the primary oscillator input
module osc_partner #(
  parameter int HALF_NS = 70
) (
  input wire logic run,
  output logic tick
);
  timeunit 1ns;
  timeprecision 100ps;
  initial tick = 1'b0;
  // a failed crystal just stops, no further edges
  always #(HALF_NS) if (run) tick = ~tick;
endmodule

// *** test/clk_sel_properties.sv ***
// checker for the system clock source selector
module clk_sel_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire clk_src_pkg::config_t cfgIn,
  input wire logic pllUsbTick,
  input wire logic switchRequestSet,
  input wire logic [2:0] newSourceField,
  input wire logic clockFailClear,
  input wire logic usbClkTick,
  input wire logic switchRequestBit,
  input wire clk_src_pkg::status_t status
);
  import clk_src_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] destQ;
  // refused codes while idle never fall, so a stale capture is harmless
  always_ff @(posedge sys_clk)
  begin
    if (switchRequestSet && !switchRequestBit) destQ <= newSourceField;
  end
  property p_sw_en;
    status.configValid |-> status.switchEnabled == !cfgIn.switchMonitorCfg[1];
  endproperty
  a_sw_en: assert property (p_sw_en) else $error("switch enable wrong");
  property p_mon_en;
    status.configValid |-> status.monitorEnabled == (cfgIn.switchMonitorCfg == 2'h0);
  endproperty
  a_mon_en: assert property (p_mon_en) else $error("monitor enable wrong");
  property p_rsvd;
    status.configValid |-> status.currentSourceField != 3'h6;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved source running");
  property p_ignore;
    status.configValid && !status.switchEnabled |-> !switchRequestBit && !status.switchBusy;
  endproperty
  a_ignore: assert property (p_ignore) else $error("switch while disabled");
  property p_take;
    status.configValid && status.switchEnabled && !status.switchBusy && !switchRequestBit
      && switchRequestSet && newSourceField != status.currentSourceField
      && newSourceField inside {3'h0, 3'h1, 3'h4, 3'h5, 3'h7} |-> ##[1:2] switchRequestBit;
  endproperty
  a_take: assert property (p_take) else $error("switch request not taken");
  property p_done;
    $fell(switchRequestBit) |-> ##[0:1] status.currentSourceField == destQ;
  endproperty
  a_done: assert property (p_done) else $error("wrong source after switch");
  property p_fail_en;
    $rose(status.clockFailFlag) |-> status.monitorEnabled;
  endproperty
  a_fail_en: assert property (p_fail_en) else $error("fail flag with monitor off");
  property p_flag_hold;
    status.clockFailFlag && !clockFailClear |=> status.clockFailFlag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("fail flag dropped");
  property p_usb;
    $past(rst_n, 4) && $past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n)
      |-> usbClkTick == $past(pllUsbTick, 4);
  endproperty
  a_usb: assert property (p_usb) else $error("usb clock not delayed copy");
endmodule

bind system_clock_source_select clk_sel_checker chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .cfgIn(cfgIn),
  .pllUsbTick(pllUsbTick),
  .switchRequestSet(switchRequestSet),
  .newSourceField(newSourceField),
  .clockFailClear(clockFailClear),
  .usbClkTick(usbClkTick),
  .switchRequestBit(switchRequestBit),
  .status(status)
);

// *** test/testbench.sv ***
// self-checking bench for the system clock source selector
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import clk_src_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, run = 1'b1, primaryOscTick;
  logic fastRcTick = 1'b0, secondaryOscTick = 1'b0, lowPowerRcTick = 1'b0;
  logic pllSysTick = 1'b0, pllUsbTick = 1'b0, switchRequestSet = 1'b0, clockFailClear = 1'b0;
  logic [2:0] fastRcDivSel = 3'h0, newSourceField = 3'h0;
  logic [31:0] lfsrQ = 32'h0001_3aaa;
  config_t cfgIn = 8'h00;
  status_t status;
  pri_mode_t primaryMode;
  logic switchRequestBit;
  logic sysClkTick, instrClkTick, oscOutPinO, oscOutPinOe, pllEnable;
  logic sysLast = 1'b0, instrLast = 1'b0;
  int checks = 0, miscompares = 0, k, m, c, s, e, sysRises = 0, instrFlips = 0;
  int tbl[13] = '{31, 30, 29, 28, 11, 3, 18, 10, 2, 25, 24, 26, 19};
  always #12.5 sys_clk = ~sys_clk;
  always #60 fastRcTick = ~fastRcTick;
  always #170 secondaryOscTick = ~secondaryOscTick;
  always #130 lowPowerRcTick = ~lowPowerRcTick;
  always #55 pllSysTick = ~pllSysTick;
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  always @(posedge sys_clk)
  begin
    #2;
    lfsrQ = lfsr(lfsrQ);
    pllUsbTick = lfsrQ[0];
  end
  osc_partner xtal (.run(run), .tick(primaryOscTick));
  system_clock_source_select #(.FAIL_TIMEOUT(20)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .cfgIn(cfgIn), .primaryOscTick(primaryOscTick),
    .secondaryOscTick(secondaryOscTick), .fastRcTick(fastRcTick),
    .lowPowerRcTick(lowPowerRcTick), .pllSysTick(pllSysTick), .pllUsbTick(pllUsbTick),
    .fastRcDivSel(fastRcDivSel), .switchRequestSet(switchRequestSet),
    .newSourceField(newSourceField), .clockFailClear(clockFailClear), .sysClkTick(sysClkTick),
    .instrClkTick(instrClkTick), .usbClkTick(), .oscOutPinO(oscOutPinO),
    .oscOutPinOe(oscOutPinOe), .pllEnable(pllEnable),
    .primaryMode(primaryMode), .switchRequestBit(switchRequestBit), .status(status)
  );
  // counted on the falling edge, where the registered ticks have settled
  always @(negedge sys_clk)
  begin
    if (!rst_n)
    begin
      sysRises = 0;
      instrFlips = 0;
    end
    else
    begin
      if (sysClkTick === 1'b1 && sysLast === 1'b0)
        sysRises++;
      if (instrClkTick !== instrLast)
        instrFlips++;
    end
    sysLast = sysClkTick;
    instrLast = instrClkTick;
  end
  // invalid power-on pairs fall back to the divided fast rc
  function automatic int srcModel(int m, int c);
    if (c == 6 || (c == 2 && m == 3) || (c == 3 && m > 1)) return 7;
    return c;
  endfunction
  function automatic int modeModel(int m, int c);
    if (c == 2) return m + 1;
    if (c == 3) return 4 + m;
    return 0;
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string n, logic [2:0] got, int exp);
    checks++;
    if (got !== exp[2:0])
    begin
      miscompares++;
      $display("wrong value %s expected %0d seen %0d", n, exp, got);
    end
  endtask
  task automatic tmo(logic ok);
    if (ok !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic bootUp(config_t cf, int n);
    rst_n = 1'b0;
    cfgIn = cf;
    fastRcDivSel = lfsrQ[2:0];
    cyc(n);
    rst_n = 1'b1;
    for (k = 0; k < 20 && status.configValid !== 1'b1; k++) cyc(1);
    tmo(status.configValid);
  endtask
  task automatic sendReq(logic [2:0] code);
    switchRequestSet = 1'b1;
    newSourceField = code;
    cyc(1);
    switchRequestSet = 1'b0;
  endtask
  task automatic waitIdle;
    for (k = 0; k < 800 && switchRequestBit !== 1'b0; k++) cyc(1);
    tmo(!switchRequestBit);
  endtask
  initial
  begin
    cyc(1);
    foreach (tbl[i])
    begin
      m = tbl[i] / 8;
      c = tbl[i] % 8;
      bootUp({m[1:0], c[2:0], 2'(i % 4), 1'((i / 2) % 2)}, i == 0 ? 16 : 2);
      s = srcModel(m, c);
      e = (s == 2 && m == 0) || (m == 3 && (i / 2) % 2 == 0);
      chk("source", status.currentSourceField, s);
      chk("mode", primaryMode, modeModel(m, s));
      chk("pll", {2'h0, pllEnable}, s == 1 || s == 3);
      chk("pin enable", {2'h0, oscOutPinOe}, e);
      if (e != 0)
        chk("pin data", {2'h0, oscOutPinO}, instrClkTick);
      chk("switch on", {2'h0, status.switchEnabled}, (i % 4) < 2);
      chk("monitor on", {2'h0, status.monitorEnabled}, (i % 4) == 0);
    end
    $display("power-on table done");
    bootUp(8'hfa, 2);
    sendReq(3'h5);
    cyc(1);
    chk("busy", {2'h0, switchRequestBit}, 1);
    sendReq(3'h0);
    waitIdle();
    chk("after switch", status.currentSourceField, 5);
    sendReq(3'h6);
    cyc(4);
    chk("reserved", status.currentSourceField, 5);
    sendReq(3'h1);
    cyc(1);
    waitIdle();
    chk("pll switch", status.currentSourceField, 1);
    chk("pll on", {2'h0, pllEnable}, 1);
    cyc(40);
    chk("pin enable", {2'h0, oscOutPinOe}, 1);
    chk("pin data", {2'h0, oscOutPinO}, instrClkTick);
    chk("sys running", {2'h0, sysRises > 4}, 1);
    chk("instr rate", {2'h0, instrFlips == sysRises}, 1);
    $display("switching done");
    bootUp(8'hfc, 2);
    sendReq(3'h5);
    cyc(6);
    chk("locked", status.currentSourceField, 7);
    chk("no busy", {2'h0, switchRequestBit}, 0);
    $display("disabled switch done");
    bootUp(8'h90, 2);
    run = 1'b0;
    for (k = 0; k < 200 && status.clockFailFlag !== 1'b1; k++) cyc(1);
    chk("fail flag", {2'h0, status.clockFailFlag}, 1);
    run = 1'b1;
    clockFailClear = 1'b1;
    cyc(2);
    clockFailClear = 1'b0;
    cyc(1);
    chk("fail cleared", {2'h0, status.clockFailFlag}, 0);
    $display("fail monitor done");
    stop_test();
  end
endmodule
